// ### rtl/hub_ctrl_pkg.sv
package hub_ctrl_pkg;

  // ==========================================================
  // register map (word offsets are byte addresses)
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CLKSEL   = 8'h10;

  localparam int IRQ_W = 4;

  // control register fields
  localparam int CTL_CONNECT_HOLD = 0;
  localparam int CTL_SUSP_SELECT  = 1;
  localparam int CTL_INIT_DONE    = 2;

  // reset values
  localparam logic             CONNECT_HOLD_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST     = 4'h0;

  // ==========================================================
  // reference clock frequency codes, in units of 100 kHz
  localparam logic [9:0] FREQ_P00 = 10'h180;
  localparam logic [9:0] FREQ_P01 = 10'h104;
  localparam logic [9:0] FREQ_P10 = 10'h0c0;
  localparam logic [9:0] FREQ_P11 = 10'h078;
  localparam logic [9:0] FREQ_S00 = 10'h0f0;
  localparam logic [9:0] FREQ_S01 = 10'h10e;
  localparam logic [9:0] FREQ_S10 = 10'h0fa;
  localparam logic [9:0] FREQ_S11 = 10'h1f4;

  // ==========================================================
  // timing
  localparam int CLK_MHZ      = 25;
  localparam int INIT_TIME_US = 3000;
  localparam int INIT_CYCLES  = INIT_TIME_US * CLK_MHZ;
  localparam int CNT_W        = 24;

  typedef enum logic [1:0] {
    STAGE_STANDBY = 2'b00,
    STAGE_INIT    = 2'b01,
    STAGE_CONNECT = 2'b10,
    STAGE_COMM    = 2'b11
  } stage_type;

  typedef struct packed {
    logic [2:0] pipe;
    logic       level;
  } sync_type;

  typedef struct packed {
    logic [1:0]  htrans;
    logic        hwrite;
    logic [7:0]  haddr;
    logic        hsel;
  } ahb_addr_type;

endpackage : hub_ctrl_pkg

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import hub_ctrl_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  sync_type state;
  sync_type next_state;

  // ==========================================================
  // three stages; a change counts once stages two and three agree
  always_comb begin
    next_state = state;
    next_state.pipe = {state.pipe[1:0], pin_i};
    if (state.pipe[2] == state.pipe[1]) begin
      next_state.level = state.pipe[2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= '{pipe: {3{RST_VAL}}, level: RST_VAL};
    end else begin
      state <= next_state;
    end
  end

  assign level_o = state.level;

endmodule : pin_sync

// ### rtl/hub_startup_ctrl.sv
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] low chip reset holds the block reset, in standby
// [R2] connect input high moves the hub into communication
// [R3] connect input low: wait for software to negate connect hold
// [R4] connect input high: enter communication ignoring connect hold
// [R5] rising edge on connect input leads into communication
// [R6] system must not raise connect input while in standby
// [R7] logic uses rising edges of the reference clock only
// [R8] interrupt pin high at init selects primary frequency set
// [R9] interrupt pin low at init selects secondary frequency set
// [R10] external source pulls interrupt pin low at init, then releases
// [R11] interrupt output is open drain, pulls low when active
// [R12] status register captures events, mask selects which interrupt
// [R13] status bits stay set until software clears them
// [R14] latched status bit stays set after its condition ends
// [R15] bits set only on a fresh rising event
// [R16] suspend select makes interrupt show configured and suspend level
// [R17] general mode: pin falls on enabled event, rises after clear
// [R18] suspend mode: low if unconfigured or suspended, else high
// [R19] frequency straps latched at init and kept afterwards
// [R20] interrupt asserted while any status bit and its mask are set; code does this only while suspend select is clear
module hub_startup_ctrl
  import hub_ctrl_pkg::*;
#(
  parameter int INIT_COUNT = INIT_CYCLES
) (
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic              chip_reset_n_i,
  input  wire logic              hub_connect_i,
  input  wire logic [1:0]        ref_sel_i,
  input  wire logic              irq_pin_i,
  input  wire logic [IRQ_W-1:0]  irq_cond_i,
  input  wire logic              hub_configured_i,
  input  wire logic              hub_suspended_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic                   irq_pin_o,
  output logic                   irq_pin_oe_o,
  output logic [9:0]             ref_freq_o,
  output logic                   hub_comm_o,
  output logic                   standby_o
);

  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_COUNT - 1);

  typedef struct packed {
    stage_type          stage;
    logic [CNT_W-1:0]   count;
    logic               connect_hold;
    logic               susp_select;
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   cond_prev;
    logic               connect_prev;
    logic [1:0]         sel_latched;
    logic               bank_primary;
    logic [9:0]         freq;
    ahb_addr_type       ap;
    logic [31:0]        rdata;
    logic               irq_drive;
    logic               in_comm;
    logic               in_standby;
  } core_state_type;

  core_state_type state;
  core_state_type next_state;

  logic            reset_n_s;
  logic            connect_s;
  logic            irq_pin_s;
  logic [1:0]      sel_s;
  logic [IRQ_W-1:0] rise;
  logic            wr_fire;
  logic            rd_fire;
  logic            irq_active;

  // ==========================================================
  // pin synchronisers
  pin_sync #(.RST_VAL(1'b0)) u_sync_rst (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (chip_reset_n_i),
    .level_o    (reset_n_s)
  );
  pin_sync #(.RST_VAL(1'b0)) u_sync_con (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (hub_connect_i),
    .level_o    (connect_s)
  );
  // external pull-up keeps the pin high unless something drives it
  pin_sync #(.RST_VAL(1'b1)) u_sync_irq (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (irq_pin_i),
    .level_o    (irq_pin_s)
  );
  pin_sync #(.RST_VAL(1'b0)) u_sync_sel0 (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (ref_sel_i[0]),
    .level_o    (sel_s[0])
  );
  pin_sync #(.RST_VAL(1'b0)) u_sync_sel1 (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (ref_sel_i[1]),
    .level_o    (sel_s[1])
  );

  // ==========================================================
  // frequency lookup
  function automatic logic [9:0] freq_of(input logic primary,
                                         input logic [1:0] sel);
    logic [9:0] f;
    f = FREQ_P00;
    unique case ({primary, sel})
      3'h4: f = FREQ_P00;
      3'h5: f = FREQ_P01;
      3'h6: f = FREQ_P10;
      3'h7: f = FREQ_P11;
      3'h0: f = FREQ_S00;
      3'h1: f = FREQ_S01;
      3'h2: f = FREQ_S10;
      3'h3: f = FREQ_S11;
    endcase
    return f;
  endfunction : freq_of

  // fresh rising events only
  assign rise = irq_cond_i & ~state.cond_prev; // see [R15]
  assign wr_fire = state.ap.hsel && state.ap.htrans[1] && state.ap.hwrite;
  assign rd_fire = hsel_i && htrans_i[1] && !hwrite_i && hready_i;
  assign irq_active = |(state.irq_stat & state.irq_mask); // see [R20]

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    next_state.cond_prev = irq_cond_i;
    next_state.connect_prev = connect_s;

    // sticky status; a clear write loses against a same-cycle event
    if (wr_fire && state.ap.haddr == ADDR_IRQ_STAT) begin
      next_state.irq_stat = state.irq_stat & ~hwdata_i[IRQ_W-1:0];
    end
    next_state.irq_stat = next_state.irq_stat | rise; // see [R12] [R13]
    // see [R14]: no path clears a bit when its condition drops

    if (wr_fire) begin
      unique case (state.ap.haddr)
        ADDR_CONTROL: begin
          next_state.connect_hold = hwdata_i[CTL_CONNECT_HOLD];
          next_state.susp_select  = hwdata_i[CTL_SUSP_SELECT];
        end
        ADDR_IRQ_MASK: next_state.irq_mask = hwdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end

    unique case (state.stage)
      STAGE_STANDBY: begin
        next_state.count = '0;
        if (reset_n_s) begin
          next_state.stage = STAGE_INIT;
        end
      end
      STAGE_INIT: begin
        // straps and bank caught continuously, last sample kept
        next_state.sel_latched  = sel_s; // see [R19]
        next_state.bank_primary = irq_pin_s; // see [R8] [R9] [R10]
        next_state.count = state.count + 1'b1;
        if (state.count == INIT_LAST) begin
          next_state.freq  = freq_of(irq_pin_s, sel_s);
          next_state.stage = STAGE_CONNECT;
        end
      end
      STAGE_CONNECT: begin
        // see [R2] [R4] [R5]: high level or rising edge
        if (connect_s || (connect_s && !state.connect_prev)) begin
          next_state.stage = STAGE_COMM;
        end else if (!state.connect_hold) begin // see [R3]
          next_state.stage = STAGE_COMM;
        end
      end
      STAGE_COMM: ;
    endcase

    if (state.susp_select) begin
      next_state.irq_drive = !hub_configured_i || hub_suspended_i; // see [R18]
    end else begin
      next_state.irq_drive = |(next_state.irq_stat & next_state.irq_mask);
    end // see [R16] [R17]

    next_state.ap = '{htrans: htrans_i, hwrite: hwrite_i,
                      haddr: haddr_i[7:0], hsel: hsel_i && hready_i};
    next_state.rdata = '0;
    if (rd_fire) begin
      unique case (haddr_i[7:0])
        ADDR_CONTROL:  next_state.rdata = {29'h0, state.stage != STAGE_INIT,
                                           state.susp_select,
                                           state.connect_hold};
        ADDR_STATUS:   next_state.rdata = {29'h0, state.bank_primary,
                                           state.stage};
        ADDR_IRQ_STAT: next_state.rdata = {28'h0, state.irq_stat};
        ADDR_IRQ_MASK: next_state.rdata = {28'h0, state.irq_mask};
        ADDR_CLKSEL:   next_state.rdata = {20'h0, state.freq,
                                           state.sel_latched};
        default:       next_state.rdata = '0;
      endcase
    end

    // standby resets stage, control, status, mask and drive; straps, frequency and bus pipe kept; see [R1]
    if (!reset_n_s) begin
      next_state.stage        = STAGE_STANDBY;
      next_state.connect_hold = CONNECT_HOLD_RST;
      next_state.susp_select  = 1'b0;
      next_state.irq_stat     = '0;
      next_state.irq_mask     = IRQ_MASK_RST;
      next_state.irq_drive    = 1'b0;
    end
    // stage flags registered so the pins come straight from flops
    next_state.in_comm    = next_state.stage == STAGE_COMM;
    next_state.in_standby = next_state.stage == STAGE_STANDBY;
  end

  // ==========================================================
  // registers, all on the rising edge; see [R7]
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= '{stage: STAGE_STANDBY, count: '0,
                 connect_hold: CONNECT_HOLD_RST, susp_select: 1'b0,
                 irq_stat: '0, irq_mask: IRQ_MASK_RST, cond_prev: '0,
                 connect_prev: 1'b0, sel_latched: 2'b00,
                 bank_primary: 1'b1, freq: FREQ_P00, ap: '0,
                 rdata: '0, irq_drive: 1'b0, in_comm: 1'b0,
                 in_standby: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  // open drain: output level is always low, enable pulls; see [R11]
  assign irq_pin_o    = 1'b0;
  assign irq_pin_oe_o = state.irq_drive;
  assign hrdata_o     = state.rdata;
  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign ref_freq_o   = state.freq;
  assign hub_comm_o   = state.in_comm;
  assign standby_o    = state.in_standby;

  // ==========================================================
  // checks
  sequence s_enabled_event;
    !state.susp_select && |(rise & state.irq_mask);
  endsequence

  chk_irq_on_event: assert property (@(posedge core_clk_i) // see [R17]
    disable iff (srst_i) (s_enabled_event and reset_n_s) |=> irq_pin_oe_o)
    else $error("enabled event did not pull interrupt");

  chk_irq_follows: assert property (@(posedge core_clk_i) // see [R20]
    disable iff (srst_i) (!state.susp_select && !$past(state.susp_select)
                          && !$past(srst_i))
      |-> (irq_pin_oe_o == irq_active))
    else $error("interrupt not tied to masked status");

  chk_stat_sticky: assert property (@(posedge core_clk_i) // see [R14]
    disable iff (srst_i) (reset_n_s && !wr_fire && !srst_i)
      |=> ((state.irq_stat & $past(state.irq_stat)) == $past(state.irq_stat)))
    else $error("status bit dropped without clear");

  chk_stat_fresh: assert property (@(posedge core_clk_i) // see [R15]
    disable iff (srst_i) (state.cond_prev == irq_cond_i && !wr_fire)
      |=> $stable(state.irq_stat) || $past(!reset_n_s))
    else $error("status set without new event");

  chk_standby_hold: assert property (@(posedge core_clk_i) // see [R1]
    disable iff (srst_i) !reset_n_s |=> standby_o)
    else $error("left standby while reset low");

  chk_connect_auto: assert property (@(posedge core_clk_i) // see [R4]
    disable iff (srst_i) (state.stage == STAGE_CONNECT && connect_s
                          && reset_n_s) |=> hub_comm_o)
    else $error("connect high did not enter communication");

  chk_connect_hold: assert property (@(posedge core_clk_i) // see [R3]
    disable iff (srst_i) (state.stage == STAGE_CONNECT && !connect_s
                          && state.connect_hold) |=> !hub_comm_o)
    else $error("left connect stage while held");

  chk_susp_level: assert property (@(posedge core_clk_i) // see [R18]
    disable iff (srst_i) (state.susp_select && reset_n_s
                          && $past(reset_n_s) && $past(state.susp_select))
      |-> irq_pin_oe_o == $past(!hub_configured_i || hub_suspended_i))
    else $error("suspend level wrong");

  chk_freq_bank: assert property (@(posedge core_clk_i) // see [R9]
    disable iff (srst_i) (state.stage == STAGE_INIT && state.count ==
                          INIT_LAST && reset_n_s && !irq_pin_s
                          && sel_s == 2'b11) |=> ref_freq_o == FREQ_S11)
    else $error("secondary frequency not selected");

endmodule : hub_startup_ctrl

// ### dv/soc_model.sv
`timescale 1ns/1ps
// ==========================================================
// system processor side: reset, connect and interrupt wire
module soc_model #(
  parameter int HOLD = 40
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic reset_req_n_i,
  input  wire logic connect_req_i,
  input  wire logic sec_bank_i,
  input  wire logic irq_oe_i,
  input  wire logic standby_i,
  output logic      chip_reset_n_o,
  output logic      hub_connect_o,
  output logic      irq_wire_o
);
  logic [7:0] hold_cnt;

  // counts cycles since the hub left standby
  always_ff @(posedge core_clk_i) begin
    if (srst_i || standby_i) begin
      hold_cnt <= 8'h00;
    end else if (hold_cnt != 8'hff) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  assign chip_reset_n_o = reset_req_n_i;
  // gated so the pin never rises while the hub sleeps
  assign hub_connect_o  = connect_req_i & reset_req_n_i
                          & ~standby_i;
  // with sec_bank set, pull low through init, then let go and just listen
  assign irq_wire_o = ~(irq_oe_i |
                        (sec_bank_i & (int'(hold_cnt) < HOLD)));
endmodule : soc_model

// ### dv/hub_startup_ctrl_tb.sv
`timescale 1ns/1ps
module hub_startup_ctrl_tb;
  import hub_ctrl_pkg::*;
  logic             clk = 1'b0;
  logic             srst = 1'b1;
  logic             rst_req_n = 1'b0;
  logic             conn_req = 1'b0;
  logic             sec_bank = 1'b0;
  logic [1:0]       ref_sel = 2'h0;
  logic [IRQ_W-1:0] cond = 4'h0;
  logic             cfg = 1'b0;
  logic             susp = 1'b0;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  logic [31:0]      hrdata;
  logic             hrdy;
  logic             hresp;
  logic             irq_o;
  logic             oe;
  logic [9:0]       freq;
  logic             comm;
  logic             standby;
  logic             chip_rst_n;
  logic             connect;
  logic             wire_lvl;
  int               n_mismatch = 0;
  int               samples_checked = 0;
  int               cyc = 0;

  always #20 clk = ~clk;

  hub_startup_ctrl #(.INIT_COUNT(20)) uut (
    .core_clk_i(clk), .srst_i(srst), .chip_reset_n_i(chip_rst_n),
    .hub_connect_i(connect), .ref_sel_i(ref_sel), .irq_pin_i(wire_lvl),
    .irq_cond_i(cond), .hub_configured_i(cfg), .hub_suspended_i(susp),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .irq_pin_o(irq_o),
    .irq_pin_oe_o(oe), .ref_freq_o(freq), .hub_comm_o(comm),
    .standby_o(standby));

  soc_model soc (
    .core_clk_i(clk), .srst_i(srst), .reset_req_n_i(rst_req_n),
    .connect_req_i(conn_req), .sec_bank_i(sec_bank), .irq_oe_i(oe),
    .standby_i(standby), .chip_reset_n_o(chip_rst_n),
    .hub_connect_o(connect), .irq_wire_o(wire_lvl));

  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // ==========================================================
  // bus master: called at a rising edge, returns at one
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rdat = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(n, x, e);
  endtask : rd

  task automatic wait_stage(input logic [1:0] st);
    logic [31:0] x;
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, ADDR_STATUS, 32'h0, x);
      if (x[1:0] === st) break;
    end
    check("stage", {30'h0, x[1:0]}, {30'h0, st});
  endtask : wait_stage

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n

  task automatic boot(input logic s, input logic [1:0] sel, input logic c);
    rst_req_n <= 1'b0;
    sec_bank <= s;
    ref_sel <= sel;
    conn_req <= c;
    wait_n(8);
    check("standby", {31'h0, standby}, 32'h1);
    rst_req_n <= 1'b1;
  endtask : boot

  // ==========================================================
  // scenarios
  task automatic t_regs();
    check("freq rst", {22'h0, freq}, 32'h180);
    // standby is not the init stage, so the finished bit reads one
    rd("control", ADDR_CONTROL, 32'h5);
    rd("mask", ADDR_IRQ_MASK, 32'h0);
    wr(8'h14, 32'hffff_ffff);
    rd("unmapped", 8'h14, 32'h0);
    check("resp", {31'h0, hresp}, 32'h0);
  endtask : t_regs

  task automatic t_freq();
    logic [9:0] tab [8] = '{10'h180, 10'h104, 10'h0c0, 10'h078,
                            10'h0f0, 10'h10e, 10'h0fa, 10'h1f4};
    for (int i = 0; i < 8; i++) begin
      boot(i[2], i[1:0], 1'b0);
      wait_stage(2'h2);
      check("freq", {22'h0, freq}, {22'h0, tab[i]});
      rd("status", ADDR_STATUS, {29'h0, ~i[2], 2'h2});
      rd("clksel", ADDR_CLKSEL, {20'h0, tab[i], i[1:0]});
      ref_sel <= ~ref_sel;
      wait_n(6);
      check("freq held", {22'h0, freq}, {22'h0, tab[i]});
    end
  endtask : t_freq

  task automatic t_connect();
    boot(1'b0, 2'h0, 1'b0);
    wait_stage(2'h2);
    rd("control", ADDR_CONTROL, 32'h5);
    wait_n(10);
    check("held", {31'h0, comm}, 32'h0);
    wr(ADDR_CONTROL, 32'h0);
    wait_n(4);
    check("released", {31'h0, comm}, 32'h1);
    boot(1'b0, 2'h0, 1'b1);
    wait_stage(2'h3);
    check("auto", {31'h0, comm}, 32'h1);
    boot(1'b0, 2'h0, 1'b0);
    wait_stage(2'h2);
    wait_n(6);
    conn_req <= 1'b1;
    wait_n(8);
    check("rise", {31'h0, comm}, 32'h1);
  endtask : t_connect

  task automatic pin(input string n, input int d, input logic e);
    wait_n(d);
    check(n, {31'h0, wire_lvl}, {31'h0, e});
  endtask : pin

  task automatic t_irq();
    boot(1'b0, 2'h0, 1'b0);
    wait_stage(2'h2);
    wr(ADDR_IRQ_MASK, 32'h1);
    cond <= 4'h1;
    pin("event", 4, 1'b0);
    check("drive", {31'h0, irq_o}, 32'h0);
    cond <= 4'h0;
    pin("latched", 4, 1'b0);
    rd("status", ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    pin("cleared", 3, 1'b1);
    cond <= 4'h2;
    pin("masked", 4, 1'b1);
    rd("status m", ADDR_IRQ_STAT, 32'h2);
    wr(ADDR_IRQ_MASK, 32'h3);
    pin("unmasked", 3, 1'b0);
    wr(ADDR_IRQ_STAT, 32'h2);
    rd("no event", ADDR_IRQ_STAT, 32'h0);
    pin("still", 2, 1'b1);
    cond <= 4'h0;
    wait_n(2);
    cond <= 4'h2;
    pin("again", 4, 1'b0);
    wr(ADDR_CONTROL, 32'h3);
    pin("unconfig", 3, 1'b0);
    cfg <= 1'b1;
    pin("active", 3, 1'b1);
    susp <= 1'b1;
    pin("suspend", 3, 1'b0);
  endtask : t_irq

  initial begin
    wait_n(6);
    srst <= 1'b0;
    wait_n(1);
    t_regs();
    t_freq();
    t_connect();
    t_irq();
    tally_and_finish();
  end
endmodule : hub_startup_ctrl_tb
